/* File: core/eisr_pkg.sv */
// eisr_pkg: constants for the extension information and security register block
// assumes byte-wide reads by offset from the card command logic
package eisr_pkg;
    // general information descriptor offsets
    localparam logic [8:0]  GI_REV_OFS       = 9'h000;
    localparam logic [8:0]  GI_LEN_OFS       = 9'h002;
    localparam logic [8:0]  GI_NEXT_OFS      = 9'h004;
    localparam logic [8:0]  GI_PM_NEXT_OFS   = 9'h038;
    localparam logic [8:0]  GI_SFC_OFS       = 9'h040;
    localparam logic [8:0]  GI_FN_OFS        = 9'h058;
    localparam logic [8:0]  GI_END_PTR_OFS   = 9'h068;
    localparam logic [8:0]  GI_NSETS_OFS     = 9'h06a;
    localparam logic [8:0]  GI_SETADR_OFS    = 9'h06c;
    // descriptor values
    localparam logic [15:0] GI_REV_VAL       = 16'h0000;
    localparam logic [15:0] GI_LEN_VAL       = 16'h0070;
    localparam logic [7:0]  GI_NEXT_VAL      = 8'h02;
    localparam logic [15:0] GI_PM_NEXT_VAL   = 16'h0040;
    localparam logic [15:0] GI_SFC_VAL       = 16'h0002;
    localparam logic [23:0] GI_FN_VAL        = 24'h46_4550;
    localparam logic [15:0] GI_END_PTR_VAL   = 16'h0000;
    localparam logic [7:0]  GI_NSETS_VAL     = 8'h01;
    localparam logic [31:0] GI_SETADR_VAL    = 32'h0008_0000;
    // security and boot register set offsets and revision value
    localparam logic [8:0]  SB_REV_OFS       = 9'h000;
    localparam logic [8:0]  SB_CAP_OFS       = 9'h008;
    localparam logic [8:0]  SB_TOTAL_OFS     = 9'h00a;
    localparam logic [8:0]  SB_ACCESS_OFS    = 9'h00b;
    localparam logic [8:0]  SB_PROT_OFS      = 9'h010;
    localparam logic [8:0]  SB_LOCK_OFS      = 9'h011;
    localparam logic [8:0]  SB_WPAUTH_OFS    = 9'h012;
    localparam logic [7:0]  SB_REV_VAL       = 8'h00;
    // capability field codes and the zero byte
    localparam logic [2:0]  UNIT_NONE        = 3'h0;
    localparam logic [2:0]  UNIT_ONE         = 3'h1;
    localparam logic [2:0]  AUTH_HMAC256     = 3'h0;
    localparam logic [7:0]  BYTE_ZERO        = 8'h00;
endpackage

/* File: core/eisr_info_rom.sv */
// eisr_info_rom: general information descriptor of the performance extension
// assumes a 9-bit byte address; purely combinational lookup
`timescale 1ns/10ps
`default_nettype none
module eisr_info_rom
(
    // lookup
    input  wire logic [8:0] addr,
    output logic      [7:0] data
);
    logic [8:0] rel_fn;
    logic [8:0] rel_sa;

    assign rel_fn = addr - eisr_pkg::GI_FN_OFS;
    assign rel_sa = addr - eisr_pkg::GI_SETADR_OFS;

    // every byte not listed, including maker fields and unused area, is zero
    always_comb
    begin
        data = eisr_pkg::BYTE_ZERO;
        case (addr)
            eisr_pkg::GI_REV_OFS:       data = eisr_pkg::GI_REV_VAL[7:0];
            eisr_pkg::GI_REV_OFS + 9'h1: data = eisr_pkg::GI_REV_VAL[15:8];
            eisr_pkg::GI_LEN_OFS:       data = eisr_pkg::GI_LEN_VAL[7:0];
            eisr_pkg::GI_LEN_OFS + 9'h1: data = eisr_pkg::GI_LEN_VAL[15:8];
            eisr_pkg::GI_NEXT_OFS:      data = eisr_pkg::GI_NEXT_VAL;
            eisr_pkg::GI_PM_NEXT_OFS:   data = eisr_pkg::GI_PM_NEXT_VAL[7:0];
            eisr_pkg::GI_PM_NEXT_OFS + 9'h1: data = eisr_pkg::GI_PM_NEXT_VAL[15:8];
            eisr_pkg::GI_SFC_OFS:       data = eisr_pkg::GI_SFC_VAL[7:0];
            eisr_pkg::GI_SFC_OFS + 9'h1: data = eisr_pkg::GI_SFC_VAL[15:8];
            eisr_pkg::GI_END_PTR_OFS:   data = eisr_pkg::GI_END_PTR_VAL[7:0];
            eisr_pkg::GI_NSETS_OFS:     data = eisr_pkg::GI_NSETS_VAL;
            default:
            begin
                if (rel_fn < 9'h3)
                    data = eisr_pkg::GI_FN_VAL[8*rel_fn[1:0] +: 8];
                else if (rel_sa < 9'h4)
                    data = eisr_pkg::GI_SETADR_VAL[8*rel_sa[1:0] +: 8];
            end
        endcase
    end
    // header pad and maker fields fall to the zero default
endmodule
`default_nettype wire

/* File: core/eisr_top.sv */
// eisr_top: extension information and security/boot register block
// assumes the card command logic presents byte reads and the config block levels
//
// Function
// - power-off notification turns off queueing, cache and self maintenance.
// - descriptor revision at 000h reads 0000h.
// - descriptor length at 002h reads 0070h.
// - extension count at 004h reads 02h.
// - bytes 005h to 00Fh read zero.
// - power management next pointer at 038h reads 0040h.
// - performance standard function code at 040h reads 0002h.
// - capability, maker code, maker name, particular code read zero.
// - function name at 058h holds three ASCII characters, rest zero.
// - next pointer at 068h reads 0000h, ending the chain.
// - register set count at 06Ah reads 01h, next byte 00h.
// - set address at 06Ch reads 0008_0000h; unused bytes read zero.
// - security byte 8 bits 2:0 give replay unit count.
// - security byte 8 bits 5:3 give authentication method, 000b.
// - security byte 10 gives unit size in 128KB steps, zero based.
// - security byte 11 gives access size in 512B steps, zero based.
// - byte 16 bit 0 mirrors boot protection enable.
// - byte 17 bits 1:0 give the registered effective boot lock bits, set from the config bits and held until cleared.
// - byte 18 bit 0 mirrors user write protect auth control bit 0.
// - lock bits clear only after replay unit authentication.
`timescale 1ns/10ps
`default_nettype none
module eisr_top
#(
    parameter logic [2:0] UNIT_COUNT  = eisr_pkg::UNIT_ONE,
    parameter logic [7:0] UNIT_SIZE   = 8'h00,
    parameter logic [7:0] ACCESS_SIZE = 8'h00
)
(
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    // register read port, one byte per request
    input  wire logic       rd_req,
    input  wire logic       rd_space_sec,
    input  wire logic [8:0] rd_addr,
    output logic      [7:0] rd_data_ff,
    output logic            rd_valid_ff,
    // configuration block values
    input  wire logic       cfg_boot_protect,
    input  wire logic [1:0] cfg_boot_lock,
    input  wire logic       cfg_user_wp_auth,
    input  wire logic       cfg_lock_clear_req,
    input  wire logic       replay_auth_done,
    // power-off notification and performance enables
    input  wire logic       power_off_notify,
    input  wire logic       perf_enable_set,
    output logic            command_queueing_en_ff,
    output logic            cache_en_ff,
    output logic            self_maint_en_ff,
    output logic      [1:0] boot_lock_eff_ff
);
    logic [7:0] info_byte;
    logic [7:0] sec_byte;
    logic [7:0] nxt_rd_data;
    logic [1:0] nxt_boot_lock;
    logic       lock_clear_ok;

    eisr_info_rom u_info_rom
    (
        .addr (rd_addr),
        .data (info_byte)
    );

    // security set decode; unlisted bytes and bits read zero
    assign sec_byte =
        (rd_addr == eisr_pkg::SB_REV_OFS)    ? eisr_pkg::SB_REV_VAL :
        (rd_addr == eisr_pkg::SB_CAP_OFS)    ? {2'b00, eisr_pkg::AUTH_HMAC256, UNIT_COUNT} :
        (rd_addr == eisr_pkg::SB_TOTAL_OFS)  ? UNIT_SIZE :
        (rd_addr == eisr_pkg::SB_ACCESS_OFS) ? ACCESS_SIZE :
        (rd_addr == eisr_pkg::SB_PROT_OFS)   ? {7'h00, cfg_boot_protect} :
        (rd_addr == eisr_pkg::SB_LOCK_OFS)   ? {6'h00, boot_lock_eff_ff} :
        (rd_addr == eisr_pkg::SB_WPAUTH_OFS) ? {7'h00, cfg_user_wp_auth} :
        eisr_pkg::BYTE_ZERO;

    assign nxt_rd_data = rd_space_sec ? sec_byte : info_byte;

    // no write port exists, so read-only space cannot be disturbed
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            rd_data_ff  <= eisr_pkg::BYTE_ZERO;
            rd_valid_ff <= 1'b0;
        end
        else
        begin
            rd_valid_ff <= rd_req;
            if (rd_req)
                rd_data_ff <= nxt_rd_data;
        end
    end

    // locks may drop only once authentication is done; setting is free
    assign lock_clear_ok = cfg_lock_clear_req & replay_auth_done;
    assign nxt_boot_lock = lock_clear_ok ? cfg_boot_lock
                                         : (boot_lock_eff_ff | cfg_boot_lock);

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            boot_lock_eff_ff <= 2'b00;
        else
            boot_lock_eff_ff <= nxt_boot_lock;
    end

    // notification wins over a same-cycle enable request
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            command_queueing_en_ff <= 1'b0;
            cache_en_ff            <= 1'b0;
            self_maint_en_ff       <= 1'b0;
        end
        else if (power_off_notify)
        begin
            command_queueing_en_ff <= 1'b0;
            cache_en_ff            <= 1'b0;
            self_maint_en_ff       <= 1'b0;
        end
        else if (perf_enable_set)
        begin
            command_queueing_en_ff <= 1'b1;
            cache_en_ff            <= 1'b1;
            self_maint_en_ff       <= 1'b1;
        end
    end
endmodule
`default_nettype wire

/* File: sim/eisr_sva.sv */
// eisr_sva: port checker for eisr_top
// assumes sync active-low reset and a one-cycle read answer
`timescale 1ns/10ps
`default_nettype none
module eisr_sva
#(
    parameter logic [2:0] UNIT_COUNT = 3'h1
)
(
    // clock and reset
    input wire logic       core_clk,
    input wire logic       reset_n,
    // read port
    input wire logic       rd_req,
    input wire logic       rd_space_sec,
    input wire logic [8:0] rd_addr,
    input wire logic [7:0] rd_data_ff,
    input wire logic       rd_valid_ff,
    // configuration and enables
    input wire logic       cfg_boot_protect,
    input wire logic [1:0] cfg_boot_lock,
    input wire logic       cfg_user_wp_auth,
    input wire logic       cfg_lock_clear_req,
    input wire logic       replay_auth_done,
    input wire logic       power_off_notify,
    input wire logic       perf_enable_set,
    input wire logic       command_queueing_en_ff,
    input wire logic       cache_en_ff,
    input wire logic       self_maint_en_ff,
    input wire logic [1:0] boot_lock_eff_ff
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    wire logic [2:0] en_all = {command_queueing_en_ff, cache_en_ff, self_maint_en_ff};
    wire logic       sec_rd = rd_req & rd_space_sec;
    wire logic       unlock = cfg_lock_clear_req & replay_auth_done;
    property p_answer; rd_req |=> rd_valid_ff; endproperty
    property p_quiet; !rd_req |=> !rd_valid_ff; endproperty
    property p_cap; sec_rd && rd_addr == 9'h008 |=> rd_data_ff == {5'h00, UNIT_COUNT}; endproperty
    property p_prot;
        sec_rd && rd_addr == 9'h010 |=> rd_data_ff == {7'h00, $past(cfg_boot_protect)};
    endproperty
    property p_wp;
        sec_rd && rd_addr == 9'h012 |=> rd_data_ff == {7'h00, $past(cfg_user_wp_auth)};
    endproperty
    property p_off; power_off_notify |=> en_all == 3'h0; endproperty
    property p_on; perf_enable_set && !power_off_notify |=> en_all == 3'h7; endproperty
    property p_sticky;
        !unlock |=> boot_lock_eff_ff == ($past(boot_lock_eff_ff) | $past(cfg_boot_lock));
    endproperty
    property p_clear; unlock |=> boot_lock_eff_ff == $past(cfg_boot_lock); endproperty
    a_answer: assert property (p_answer) else $error("read not answered");
    a_quiet: assert property (p_quiet) else $error("stray read answer");
    a_cap: assert property (p_cap) else $error("capability byte wrong");
    a_prot: assert property (p_prot) else $error("protect mirror wrong");
    a_wp: assert property (p_wp) else $error("wp auth mirror wrong");
    a_off: assert property (p_off) else $error("enables survive power off");
    a_on: assert property (p_on) else $error("enables not set");
    a_sticky: assert property (p_sticky) else $error("lock dropped early");
    a_clear: assert property (p_clear) else $error("lock not cleared");
    c_sec: cover property (sec_rd);
    c_prio: cover property (power_off_notify && perf_enable_set);
    c_unlock: cover property (unlock);
endmodule
bind eisr_top eisr_sva #(.UNIT_COUNT(UNIT_COUNT)) eisr_sva_i (.*);
`default_nettype wire

/* File: sim/eisr_host.sv */
// eisr_host: host read model for the register port
// assumes calls come from one process after reset release
`timescale 1ns/10ps
`default_nettype none
module eisr_host
(
    // clock
    input  wire logic       core_clk,
    // read port
    output var logic        rd_req,
    output var logic        rd_space_sec,
    output var logic  [8:0] rd_addr,
    input  wire logic [7:0] rd_data_ff,
    input  wire logic       rd_valid_ff
);
    initial
    begin
        rd_req = 1'b0;
        rd_space_sec = 1'b0;
        rd_addr = 9'h000;
    end
    // a real host skips the size bytes when no replay unit exists; here all bytes are read
    task automatic rd(input logic sp, input logic [8:0] a, output logic [7:0] d, output logic ok);
        int n;
        @(posedge core_clk);
        rd_req <= 1'b1;
        rd_space_sec <= sp;
        rd_addr <= a;
        @(posedge core_clk);
        rd_req <= 1'b0;
        rd_addr <= ~a;
        ok = 1'b0;
        for (n = 0; n < 4 && !ok; n++)
        begin
            #1;
            ok = (rd_valid_ff === 1'b1);
            d = rd_data_ff;
            if (!ok) @(posedge core_clk);
        end
    endtask
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
// testbench: table reads, enables and lock mirror scenarios
// assumes eisr_top with its checker bound
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin err_total++; \
    $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module testbench;
    logic core_clk, reset_n, rd_req, rd_space_sec, rd_valid_ff, cfg_boot_protect;
    logic cfg_user_wp_auth, cfg_lock_clear_req, replay_auth_done, power_off_notify;
    logic perf_enable_set, command_queueing_en_ff, cache_en_ff, self_maint_en_ff;
    logic [8:0] rd_addr;
    logic [7:0] rd_data_ff;
    logic [1:0] cfg_boot_lock, boot_lock_eff_ff;
    int         err_total = 0;
    int         checked = 0;
    // {space, offset, byte}; size bytes use nonzero values so a stuck field shows
    logic [17:0] tab[] = '{18'h0_0000, 18'h0_0100, 18'h0_0270, 18'h0_0300, 18'h0_0402,
        18'h0_0500, 18'h0_0f00, 18'h0_3840, 18'h0_3900, 18'h0_4002, 18'h0_4100,
        18'h0_4200, 18'h0_4600, 18'h0_5600, 18'h0_5850, 18'h0_5945, 18'h0_5a46,
        18'h0_5b00, 18'h0_6800, 18'h0_6a01, 18'h0_6b00, 18'h0_6c00, 18'h0_6e08,
        18'h0_6f00, 18'h0_7000, 18'h1_ff00, 18'h2_0000, 18'h2_0100, 18'h2_0801,
        18'h2_0900, 18'h2_0a3c, 18'h2_0b7f, 18'h2_0c00, 18'h2_1300};
    eisr_top #(.UNIT_SIZE(8'h3c), .ACCESS_SIZE(8'h7f)) eisr_top_i (.*);
    eisr_host eisr_host_i (.*);
    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic rc(input logic s, input logic [8:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic ok;
        eisr_host_i.rd(s, a, d, ok);
        if (!ok)
        begin
            err_total++;
            summarize();
        end
        else
            `CHK("rd_data", e, d)
    endtask
    initial
    begin
        {reset_n, cfg_boot_protect, cfg_user_wp_auth, cfg_lock_clear_req} = 4'h0;
        {replay_auth_done, power_off_notify, perf_enable_set, cfg_boot_lock} = 5'h00;
        repeat (6) @(posedge core_clk);
        reset_n <= 1'b1;
        foreach (tab[i])
            rc(tab[i][17], tab[i][16:8], tab[i][7:0]);
        @(posedge core_clk) perf_enable_set <= 1'b1;
        @(posedge core_clk) power_off_notify <= 1'b1;
        #1 `CHK("en_on", 3'h7, {command_queueing_en_ff, cache_en_ff, self_maint_en_ff})
        @(posedge core_clk) {perf_enable_set, power_off_notify} <= 2'b00;
        #1 `CHK("en_off", 3'h0, {command_queueing_en_ff, cache_en_ff, self_maint_en_ff})
        @(posedge core_clk) {cfg_boot_protect, cfg_user_wp_auth, cfg_boot_lock} <= 4'he;
        rc(1'b1, 9'h010, 8'h01);
        rc(1'b1, 9'h012, 8'h01);
        rc(1'b1, 9'h011, 8'h02);
        @(posedge core_clk) {cfg_boot_lock, cfg_lock_clear_req} <= 3'h3;
        rc(1'b1, 9'h011, 8'h03);
        @(posedge core_clk) cfg_boot_lock <= 2'b00;
        rc(1'b1, 9'h011, 8'h03);
        @(posedge core_clk) replay_auth_done <= 1'b1;
        rc(1'b1, 9'h011, 8'h00);
        summarize();
    end
endmodule
`default_nettype wire
